// ===== core/pab_pkg.sv
// package: register map, field layout, states and carriers of the passthrough block decoder
package pab_pkg;
	// register byte offsets on the AXI4-Lite slave
	localparam logic [7:0] OFS_CB_W0 = 8'h00;
	localparam logic [7:0] OFS_CB_W1 = 8'h04;
	localparam logic [7:0] OFS_CB_W2 = 8'h08;
	localparam logic [7:0] OFS_CB_W3 = 8'h0C;
	localparam logic [7:0] OFS_CTRL = 8'h10;
	localparam logic [7:0] OFS_CFG = 8'h14;
	localparam logic [7:0] OFS_STATUS = 8'h18;
	localparam logic [7:0] OFS_RES_W0 = 8'h1C;
	localparam logic [7:0] OFS_RES_W1 = 8'h20;
	// reset values
	localparam logic [7:0] CFG_SIG_RST = 8'h00;
	localparam logic CFG_LUN_DEV_RST = 1'b0;
	// block layout
	localparam logic [7:0] SUBCMD_VALUE = 8'h24;
	localparam int BYTE_SIG = 0;
	localparam int BYTE_SUBCMD = 1;
	localparam int BYTE_FLAGS = 2;
	localparam int BYTE_MASK = 3;
	localparam int BYTE_COUNT = 4;
	localparam int BYTE_WR_BASE = 5;
	localparam int BYTE_DEVHEAD = 11;
	localparam int DEV_BIT_POS = 4;
	localparam int BSY_BIT_POS = 7;
	localparam int CFG_LUN_POS = 8;
	// taskfile register indices, matching the select mask bit order
	localparam logic [2:0] TF_ALT_STATUS = 3'h0;
	localparam logic [2:0] TF_DEVHEAD = 3'h6;
	localparam logic [3:0] TF_NONE = 4'h8;
	// status bit positions
	localparam int STS_BUSY = 0;
	localparam int STS_DONE = 1;
	localparam int STS_ATA = 2;
	localparam int STS_FAIL = 3;
	localparam int STS_HALT_DEV = 4;
	localparam int STS_HALT_PHASE = 5;
	localparam int STS_ROUTED = 6;
	// bus answers
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// action flags in their bit order 7..0
	typedef struct packed {
		logic identify_data_flag;
		logic ultra_dma_flag;
		logic device_bit_source_flag;
		logic drive_error_continue_flag;
		logic phase_error_continue_flag;
		logic skip_status_poll_flag;
		logic late_device_select_flag;
		logic register_read_only_flag;
	} pab_flags_t;

	// one taskfile access request
	typedef struct packed {
		logic we;
		logic [2:0] addr;
		logic [7:0] wdata;
	} pab_tf_req_t;

	typedef enum logic [3:0] {
		ST_IDLE, ST_DECODE, ST_POLL, ST_SEL_EARLY, ST_WRITE, ST_SEL_LATE, ST_XFER, ST_READ, ST_DONE
	} pab_state_t;
endpackage

// ===== core/pab_decode.sv
// block recogniser: signature, subcommand, flags and field checks
`timescale 1ns/1ps
module pab_decode (
	// block and configuration
	input wire logic [127:0] i_block,
	input wire logic [7:0] i_signature,
	input wire logic i_lun_dev,
	// decoded fields
	output logic o_is_ata,
	output pab_pkg::pab_flags_t o_flags,
	output logic [7:0] o_mask,
	output logic o_count_ok,
	output logic [7:0] o_devhead
);
	logic [7:0] count;
	logic [7:0] dh_raw;
	logic dev;

	// recognition needs both leading bytes
	assign o_is_ata = (i_block[8*pab_pkg::BYTE_SIG +: 8] == i_signature) &&
		(i_block[8*pab_pkg::BYTE_SUBCMD +: 8] == pab_pkg::SUBCMD_VALUE);
	assign o_flags = pab_pkg::pab_flags_t'(i_block[8*pab_pkg::BYTE_FLAGS +: 8]);
	assign o_mask = i_block[8*pab_pkg::BYTE_MASK +: 8];
	// legal counts are zero or a single set bit
	assign count = i_block[8*pab_pkg::BYTE_COUNT +: 8];
	assign o_count_ok = ((count & (count - 8'h01)) == 8'h00);
	// device bit from the block or from the start-up assignment
	assign dh_raw = i_block[8*pab_pkg::BYTE_DEVHEAD +: 8];
	assign dev = o_flags.device_bit_source_flag ? dh_raw[pab_pkg::DEV_BIT_POS] : i_lun_dev;
	assign o_devhead = {dh_raw[7:5], dev, dh_raw[3:0]};
endmodule

// ===== core/pab_result_mem.sv
// eight-byte result store, byte writes, registered word reads
`timescale 1ns/1ps
module pab_result_mem (
	// clock
	input wire logic i_clk_sys,
	// write port
	input wire logic i_we,
	input wire logic [2:0] i_waddr,
	input wire logic [7:0] i_wdata,
	// read port
	input wire logic i_re,
	input wire logic i_rword,
	output logic [31:0] o_rdata
);
	logic [7:0] mem [0:7];

	// byte write
	always_ff @(posedge i_clk_sys) begin
		if (i_we) begin
			mem[i_waddr] <= i_wdata;
		end
	end

	// word read, byte 0 of a word in the low lane
	always_ff @(posedge i_clk_sys) begin
		if (i_re) begin
			o_rdata <= {mem[{i_rword, 2'h3}], mem[{i_rword, 2'h2}], mem[{i_rword, 2'h1}], mem[{i_rword, 2'h0}]};
		end
	end
endmodule

// ===== core/pab_core.sv
// passthrough block decoder and taskfile sequencer with AXI4-Lite registers
`timescale 1ns/1ps
module pab_core (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst,
	// axi4-lite write address and data
	input wire logic i_s_axi_awvalid,
	output logic o_s_axi_awready,
	input wire logic [7:0] i_s_axi_awaddr,
	input wire logic i_s_axi_wvalid,
	output logic o_s_axi_wready,
	input wire logic [31:0] i_s_axi_wdata,
	input wire logic [3:0] i_s_axi_wstrb,
	// axi4-lite write response
	output logic o_s_axi_bvalid,
	input wire logic i_s_axi_bready,
	output logic [1:0] o_s_axi_bresp,
	// axi4-lite read
	input wire logic i_s_axi_arvalid,
	output logic o_s_axi_arready,
	input wire logic [7:0] i_s_axi_araddr,
	output logic o_s_axi_rvalid,
	input wire logic i_s_axi_rready,
	output logic [31:0] o_s_axi_rdata,
	output logic [1:0] o_s_axi_rresp,
	// taskfile access port
	output logic o_tf_req,
	output pab_pkg::pab_tf_req_t o_tf_cmd,
	input wire logic i_tf_ack,
	input wire logic [7:0] i_tf_rdata,
	// data phase control
	output logic o_xfer_start,
	output logic o_xfer_udma,
	output logic o_xfer_ident,
	output logic o_xfer_abort,
	input wire logic i_xfer_done,
	input wire logic i_drive_err,
	input wire logic i_phase_err,
	// plain command path
	output logic o_plain_valid,
	output logic [127:0] o_plain_block
);
	////////////////////////////////////////////////////////////////////////
	logic aw_hold_q, w_hold_q, bvalid_q, rd_pend_q, rvalid_q, arready_q;
	logic awready_q, wready_q;
	logic [7:0] awaddr_q, araddr_q;
	logic [31:0] wdata_q, rdata_q;
	logic [3:0] wstrb_q;
	logic [1:0] bresp_q, rresp_q;
	logic [127:0] block_q;
	logic [7:0] sig_q;
	logic lun_dev_q, go_q;
	logic [6:0] status_q;
	pab_pkg::pab_state_t state_q;
	logic [3:0] idx_q;
	logic tf_req_q;
	pab_pkg::pab_tf_req_t tf_cmd_q;
	logic xfer_start_q, xfer_udma_q, xfer_ident_q, xfer_abort_q;
	logic plain_valid_q;
	logic [127:0] plain_block_q;
	logic dec_is_ata, dec_count_ok;
	pab_pkg::pab_flags_t flags;
	logic [7:0] mask, devhead;
	logic wr_fire, ar_fire, mem_we;
	logic [7:0] mem_wdata;
	logic [31:0] mem_rdata;

	// next selected register at or after a start index, device/head left out
	function automatic logic [3:0] next_sel(input logic [7:0] m, input logic [3:0] from);
		logic [3:0] r;
		r = pab_pkg::TF_NONE;
		for (int i = 7; i >= 0; i--) begin
			if (m[i] && (4'(i) >= from) && (3'(i) != pab_pkg::TF_DEVHEAD)) begin
				r = 4'(i);
			end
		end
		return r;
	endfunction

	// write value of one taskfile register out of bytes five onward
	function automatic logic [7:0] wr_value(input logic [127:0] b, input logic [2:0] a);
		return b[8*(pab_pkg::BYTE_WR_BASE + int'(a)) +: 8];
	endfunction

	////////////////////////////////////////////////////////////////////////
	pab_decode u_decode (
		.i_block(block_q),
		.i_signature(sig_q),
		.i_lun_dev(lun_dev_q),
		.o_is_ata(dec_is_ata),
		.o_flags(flags),
		.o_mask(mask),
		.o_count_ok(dec_count_ok),
		.o_devhead(devhead)
	);

	pab_result_mem u_result (
		.i_clk_sys(i_clk_sys),
		.i_we(mem_we),
		.i_waddr(idx_q[2:0]),
		.i_wdata(mem_wdata),
		.i_re(ar_fire),
		.i_rword(i_s_axi_araddr == pab_pkg::OFS_RES_W1),
		.o_rdata(mem_rdata)
	);

	////////////////////////////////////////////////////////////////////////
	// write channel capture, either order
	assign wr_fire = aw_hold_q && w_hold_q && !bvalid_q;
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			aw_hold_q <= 1'b0;
			w_hold_q <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
		end else begin
			if (i_s_axi_awvalid && !aw_hold_q) begin
				aw_hold_q <= 1'b1;
				awaddr_q <= i_s_axi_awaddr;
			end else if (wr_fire) begin
				aw_hold_q <= 1'b0;
			end
			if (i_s_axi_wvalid && !w_hold_q) begin
				w_hold_q <= 1'b1;
				wdata_q <= i_s_axi_wdata;
				wstrb_q <= i_s_axi_wstrb;
			end else if (wr_fire) begin
				w_hold_q <= 1'b0;
			end
		end
	end

	// readies as own flops, always the inverse of the hold flags
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			awready_q <= 1'b1;
			wready_q <= 1'b1;
		end else begin
			if (i_s_axi_awvalid && !aw_hold_q) begin
				awready_q <= 1'b0;
			end else if (wr_fire) begin
				awready_q <= 1'b1;
			end
			if (i_s_axi_wvalid && !w_hold_q) begin
				wready_q <= 1'b0;
			end else if (wr_fire) begin
				wready_q <= 1'b1;
			end
		end
	end

	// write response, unmapped and read-only offsets answer slverr
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			bvalid_q <= 1'b0;
			bresp_q <= pab_pkg::RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_q <= 1'b1;
			unique case (awaddr_q)
				pab_pkg::OFS_CB_W0, pab_pkg::OFS_CB_W1, pab_pkg::OFS_CB_W2, pab_pkg::OFS_CB_W3,
				pab_pkg::OFS_CTRL, pab_pkg::OFS_CFG: bresp_q <= pab_pkg::RESP_OKAY;
				default: bresp_q <= pab_pkg::RESP_SLVERR;
			endcase
		end else if (i_s_axi_bready) begin
			bvalid_q <= 1'b0;
		end
	end

	// software-written block, config and start pulse; block frozen while busy
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			block_q <= 128'h0;
			sig_q <= pab_pkg::CFG_SIG_RST;
			lun_dev_q <= pab_pkg::CFG_LUN_DEV_RST;
			go_q <= 1'b0;
		end else begin
			go_q <= 1'b0;
			if (wr_fire) begin
				for (int b = 0; b < 4; b++) begin
					if (wstrb_q[b] && state_q == pab_pkg::ST_IDLE && awaddr_q[7:4] == 4'h0) begin
						block_q[8*(4*int'(awaddr_q[3:2]) + b) +: 8] <= wdata_q[8*b +: 8];
					end
				end
				if (awaddr_q == pab_pkg::OFS_CFG && wstrb_q[0]) begin
					sig_q <= wdata_q[7:0];
				end
				if (awaddr_q == pab_pkg::OFS_CFG && wstrb_q[1]) begin
					lun_dev_q <= wdata_q[pab_pkg::CFG_LUN_POS];
				end
				if (awaddr_q == pab_pkg::OFS_CTRL && wstrb_q[0] && wdata_q[0] && state_q == pab_pkg::ST_IDLE) begin
					go_q <= 1'b1;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read channel, one cycle to fetch then hold until rready
	assign ar_fire = i_s_axi_arvalid && arready_q;
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			arready_q <= 1'b1;
			rd_pend_q <= 1'b0;
			rvalid_q <= 1'b0;
			araddr_q <= 8'h00;
			rdata_q <= 32'h0000_0000;
			rresp_q <= pab_pkg::RESP_OKAY;
		end else if (ar_fire) begin
			arready_q <= 1'b0;
			rd_pend_q <= 1'b1;
			araddr_q <= i_s_axi_araddr;
		end else if (rd_pend_q) begin
			rd_pend_q <= 1'b0;
			rvalid_q <= 1'b1;
			rresp_q <= pab_pkg::RESP_OKAY;
			unique case (araddr_q)
				pab_pkg::OFS_CB_W0: rdata_q <= block_q[31:0];
				pab_pkg::OFS_CB_W1: rdata_q <= block_q[63:32];
				pab_pkg::OFS_CB_W2: rdata_q <= block_q[95:64];
				pab_pkg::OFS_CB_W3: rdata_q <= block_q[127:96];
				pab_pkg::OFS_CTRL: rdata_q <= 32'h0000_0000;
				pab_pkg::OFS_CFG: rdata_q <= {23'h0, lun_dev_q, sig_q};
				pab_pkg::OFS_STATUS: rdata_q <= {25'h0, status_q};
				pab_pkg::OFS_RES_W0, pab_pkg::OFS_RES_W1: rdata_q <= mem_rdata;
				default: begin
					rdata_q <= 32'h0000_0000;
					rresp_q <= pab_pkg::RESP_SLVERR;
				end
			endcase
		end else if (rvalid_q && i_s_axi_rready) begin
			rvalid_q <= 1'b0;
			arready_q <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// sequencer: decode, poll, select, write, transfer, read
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			state_q <= pab_pkg::ST_IDLE;
			idx_q <= 4'h0;
		end else begin
			unique case (state_q)
				pab_pkg::ST_IDLE: if (go_q) state_q <= pab_pkg::ST_DECODE;
				pab_pkg::ST_DECODE: begin
					if (!dec_is_ata || !dec_count_ok) begin
						state_q <= pab_pkg::ST_DONE;
					end else if (!flags.skip_status_poll_flag) begin
						state_q <= pab_pkg::ST_POLL;
					end else if (!flags.late_device_select_flag) begin
						state_q <= pab_pkg::ST_SEL_EARLY;
					end else begin
						state_q <= flags.register_read_only_flag ? pab_pkg::ST_READ : pab_pkg::ST_WRITE;
					end
					idx_q <= flags.register_read_only_flag ? 4'h0 : next_sel(mask, 4'h0);
				end
				pab_pkg::ST_POLL: begin
					if (i_tf_ack && !i_tf_rdata[pab_pkg::BSY_BIT_POS]) begin
						if (!flags.late_device_select_flag) begin
							state_q <= pab_pkg::ST_SEL_EARLY;
						end else begin
							state_q <= flags.register_read_only_flag ? pab_pkg::ST_READ : pab_pkg::ST_WRITE;
						end
					end
				end
				pab_pkg::ST_SEL_EARLY: begin
					if (i_tf_ack) begin
						state_q <= flags.register_read_only_flag ? pab_pkg::ST_READ : pab_pkg::ST_WRITE;
					end
				end
				pab_pkg::ST_WRITE: begin
					if (idx_q == pab_pkg::TF_NONE) begin
						state_q <= flags.late_device_select_flag ? pab_pkg::ST_SEL_LATE : pab_pkg::ST_XFER;
					end else if (i_tf_ack) begin
						idx_q <= next_sel(mask, idx_q + 4'h1);
					end
				end
				pab_pkg::ST_SEL_LATE: begin
					if (i_tf_ack) begin
						state_q <= flags.register_read_only_flag ? pab_pkg::ST_DONE : pab_pkg::ST_XFER;
					end
				end
				pab_pkg::ST_XFER: begin
					if (i_drive_err && !flags.drive_error_continue_flag) begin
						state_q <= pab_pkg::ST_DONE;
					end else if (i_phase_err && !flags.phase_error_continue_flag) begin
						state_q <= pab_pkg::ST_DONE;
					end else if (i_xfer_done) begin
						state_q <= pab_pkg::ST_DONE;
					end
				end
				pab_pkg::ST_READ: begin
					if (!mask[idx_q[2:0]] || i_tf_ack) begin
						idx_q <= idx_q + 4'h1;
						if (idx_q[2:0] == 3'h7) begin
							state_q <= flags.late_device_select_flag ? pab_pkg::ST_SEL_LATE : pab_pkg::ST_DONE;
						end
					end
				end
				pab_pkg::ST_DONE: state_q <= pab_pkg::ST_IDLE;
			endcase
		end
	end

	// result bytes at offsets 0..7 by register index, zero when unselected
	assign mem_we = (state_q == pab_pkg::ST_READ) && (!mask[idx_q[2:0]] || i_tf_ack);
	assign mem_wdata = mask[idx_q[2:0]] ? i_tf_rdata : 8'h00;

	// taskfile request, held until acknowledged
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			tf_req_q <= 1'b0;
			tf_cmd_q <= '0;
		end else begin
			tf_req_q <= 1'b0;
			tf_cmd_q <= '0;
			if (!i_tf_ack || !tf_req_q) begin
				unique case (state_q)
					pab_pkg::ST_POLL: begin
						tf_req_q <= 1'b1;
						tf_cmd_q <= '{we: 1'b0, addr: pab_pkg::TF_ALT_STATUS, wdata: 8'h00};
					end
					pab_pkg::ST_SEL_EARLY, pab_pkg::ST_SEL_LATE: begin
						tf_req_q <= 1'b1;
						tf_cmd_q <= '{we: 1'b1, addr: pab_pkg::TF_DEVHEAD, wdata: devhead};
					end
					pab_pkg::ST_WRITE: begin
						tf_req_q <= (idx_q != pab_pkg::TF_NONE);
						tf_cmd_q <= '{we: 1'b1, addr: idx_q[2:0], wdata: wr_value(block_q, idx_q[2:0])};
					end
					pab_pkg::ST_READ: begin
						tf_req_q <= mask[idx_q[2:0]];
						tf_cmd_q <= '{we: 1'b0, addr: idx_q[2:0], wdata: 8'h00};
					end
					default: begin
						tf_req_q <= 1'b0;
					end
				endcase
			end
		end
	end

	// data phase start with method and identify marking, abort on halting error
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			xfer_start_q <= 1'b0;
			xfer_udma_q <= 1'b0;
			xfer_ident_q <= 1'b0;
			xfer_abort_q <= 1'b0;
		end else begin
			xfer_start_q <= 1'b0;
			xfer_abort_q <= 1'b0;
			if (state_q != pab_pkg::ST_XFER && !flags.register_read_only_flag &&
				((state_q == pab_pkg::ST_WRITE && idx_q == pab_pkg::TF_NONE && !flags.late_device_select_flag) ||
				(state_q == pab_pkg::ST_SEL_LATE && i_tf_ack))) begin
				xfer_start_q <= 1'b1;
				xfer_udma_q <= flags.ultra_dma_flag;
				xfer_ident_q <= flags.identify_data_flag;
			end
			if (state_q == pab_pkg::ST_XFER && !i_xfer_done &&
				((i_drive_err && !flags.drive_error_continue_flag) ||
				(i_phase_err && !flags.phase_error_continue_flag))) begin
				xfer_abort_q <= 1'b1;
			end
		end
	end

	// plain path hand-off of an unrecognised block, unchanged
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			plain_valid_q <= 1'b0;
			plain_block_q <= 128'h0;
		end else begin
			plain_valid_q <= (state_q == pab_pkg::ST_DECODE) && !dec_is_ata;
			if (state_q == pab_pkg::ST_DECODE && !dec_is_ata) begin
				plain_block_q <= block_q;
			end
		end
	end

	// status: set to busy alone on start, sticky outcome bits
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			status_q <= 7'h00;
		end else if (go_q) begin
			status_q <= 7'h01;
		end else begin
			if (state_q == pab_pkg::ST_DECODE) begin
				status_q[pab_pkg::STS_ATA] <= dec_is_ata;
				status_q[pab_pkg::STS_ROUTED] <= !dec_is_ata;
				status_q[pab_pkg::STS_FAIL] <= dec_is_ata && !dec_count_ok;
			end
			if (state_q == pab_pkg::ST_XFER && !i_xfer_done) begin
				if (i_drive_err && !flags.drive_error_continue_flag) status_q[pab_pkg::STS_HALT_DEV] <= 1'b1;
				else if (i_phase_err && !flags.phase_error_continue_flag) status_q[pab_pkg::STS_HALT_PHASE] <= 1'b1;
			end
			if (state_q == pab_pkg::ST_DONE) begin
				status_q[pab_pkg::STS_BUSY] <= 1'b0;
				status_q[pab_pkg::STS_DONE] <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs straight from flops
	assign o_s_axi_awready = awready_q;
	assign o_s_axi_wready = wready_q;
	assign o_s_axi_bvalid = bvalid_q;
	assign o_s_axi_bresp = bresp_q;
	assign o_s_axi_arready = arready_q;
	assign o_s_axi_rvalid = rvalid_q;
	assign o_s_axi_rdata = rdata_q;
	assign o_s_axi_rresp = rresp_q;
	assign o_tf_req = tf_req_q;
	assign o_tf_cmd = tf_cmd_q;
	assign o_xfer_start = xfer_start_q;
	assign o_xfer_udma = xfer_udma_q;
	assign o_xfer_ident = xfer_ident_q;
	assign o_xfer_abort = xfer_abort_q;
	assign o_plain_valid = plain_valid_q;
	assign o_plain_block = plain_block_q;

	////////////////////////////////////////////////////////////////////////
	// checks
	a_ata_recognised: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		state_q == pab_pkg::ST_DECODE && dec_is_ata |=> !plain_valid_q && status_q[pab_pkg::STS_ATA])
		else $error("recognised block not taken as passthrough");
	a_plain_routed: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		state_q == pab_pkg::ST_DECODE && !dec_is_ata |=> plain_valid_q && plain_block_q == $past(block_q)
		##1 state_q == pab_pkg::ST_IDLE && !tf_req_q)
		else $error("unrecognised block not routed unchanged");
	a_sig_byte: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		dec_is_ata |-> block_q[7:0] == sig_q)
		else $error("signature byte mismatch accepted");
	a_subcmd_byte: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		dec_is_ata |-> block_q[15:8] == pab_pkg::SUBCMD_VALUE)
		else $error("subcommand byte mismatch accepted");
	a_xfer_marks: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		xfer_start_q |-> xfer_ident_q == flags.identify_data_flag && xfer_udma_q == flags.ultra_dma_flag)
		else $error("transfer marking differs from flags");
	a_devhead_bit: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		tf_req_q && tf_cmd_q.we && tf_cmd_q.addr == pab_pkg::TF_DEVHEAD |-> tf_cmd_q.wdata[4] ==
		(flags.device_bit_source_flag ? block_q[8*pab_pkg::BYTE_DEVHEAD + 4] : lun_dev_q))
		else $error("device bit from wrong source");
	a_drive_halt: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		state_q == pab_pkg::ST_XFER && i_drive_err && !flags.drive_error_continue_flag && !i_xfer_done
		|=> xfer_abort_q && status_q[pab_pkg::STS_HALT_DEV] && state_q == pab_pkg::ST_DONE)
		else $error("drive error did not halt");
	a_phase_halt: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		state_q == pab_pkg::ST_XFER && !i_drive_err && i_phase_err && !flags.phase_error_continue_flag
		&& !i_xfer_done |=> xfer_abort_q && status_q[pab_pkg::STS_HALT_PHASE])
		else $error("phase error did not halt");
	a_poll_busy: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		state_q == pab_pkg::ST_POLL && i_tf_ack && i_tf_rdata[7] |=> state_q == pab_pkg::ST_POLL)
		else $error("left polling while busy");
	a_late_select: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		state_q == pab_pkg::ST_SEL_LATE |-> flags.late_device_select_flag && $past(state_q) != pab_pkg::ST_POLL)
		else $error("late selection out of order");
	a_read_no_xfer: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		flags.register_read_only_flag && status_q[pab_pkg::STS_BUSY] |-> !xfer_start_q)
		else $error("data phase during register read");
	a_zero_unsel: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		state_q == pab_pkg::ST_READ && !mask[idx_q[2:0]] |-> mem_we && mem_wdata == 8'h00 && !tf_req_q)
		else $error("unselected result not zero");
	a_bad_count: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		state_q == pab_pkg::ST_DECODE && dec_is_ata && !dec_count_ok |=> status_q[pab_pkg::STS_FAIL]
		&& state_q == pab_pkg::ST_DONE)
		else $error("illegal count not failed");
endmodule

// ===== test/pab_tf_model.sv
// taskfile partner: eight registers, alt status busy for the first reads
`timescale 1ns/1ps
module pab_tf_model #(parameter int BUSY = 2) (
	// clock, reset, pace
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic i_slow,
	// taskfile port
	input wire logic i_tf_req,
	input wire pab_pkg::pab_tf_req_t i_tf_cmd,
	output logic o_tf_ack,
	output logic [7:0] o_tf_rdata
);
	logic [7:0] regs_q [8];
	logic [3:0] wait_q, busy_q;
	// one ack a request after the wait; idle data shows the inverse
	always_ff @(posedge i_clk_sys) begin
		o_tf_ack <= 1'b0;
		o_tf_rdata <= ~o_tf_rdata;
		wait_q <= (i_tf_req && !o_tf_ack) ? wait_q + 4'h1 : 4'h0;
		if (i_rst) begin
			busy_q <= 4'(BUSY);
			for (int k = 0; k < 8; k++) regs_q[k] <= 8'h50 + 8'(k);
		end else if (i_tf_req && !o_tf_ack && wait_q >= (i_slow ? 4'h5 : 4'h0)) begin
			o_tf_ack <= 1'b1;
			if (i_tf_cmd.we) regs_q[i_tf_cmd.addr] <= i_tf_cmd.wdata;
			o_tf_rdata <= regs_q[i_tf_cmd.addr] | {busy_q != 4'h0 && i_tf_cmd.addr == 3'h0, 7'h00};
			if (busy_q != 4'h0 && i_tf_cmd.addr == 3'h0) busy_q <= busy_q - 4'h1;
		end
	end
endmodule

// ===== test/pab_core_bench.sv
// bench: bus tasks, one task a scenario, verdict
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin err_count++; $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module ata_command_block_decoder_bench;
	logic clk = 0, rst = 1, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0, xd = 0, de = 0, pe = 0, slow = 0, aut = 1;
	logic awr, wrd, bv, arr, rv, req, ack, xs, xu, xi, xa, pv;
	logic [1:0] br, rr, r, xl;
	logic [7:0] awa = 0, ara = 0, trd;
	logic [31:0] wd = 0, rd, st;
	logic [127:0] pb, pbk;
	pab_pkg::pab_tf_req_t cmd;
	logic [10:0] wq[$];
	int err_count = 0, checks = 0, polls = 0, aborts = 0;
	always #5 clk = ~clk;
	pab_core dut (.i_clk_sys(clk), .i_rst(rst), .i_s_axi_awvalid(awv), .o_s_axi_awready(awr), .i_s_axi_awaddr(awa),
		.i_s_axi_wvalid(wv), .o_s_axi_wready(wrd), .i_s_axi_wdata(wd), .i_s_axi_wstrb(4'hF), .o_s_axi_bvalid(bv),
		.i_s_axi_bready(bre), .o_s_axi_bresp(br), .i_s_axi_arvalid(arv), .o_s_axi_arready(arr), .i_s_axi_araddr(ara),
		.o_s_axi_rvalid(rv), .i_s_axi_rready(rre), .o_s_axi_rdata(rd), .o_s_axi_rresp(rr), .o_tf_req(req),
		.o_tf_cmd(cmd), .i_tf_ack(ack), .i_tf_rdata(trd), .o_xfer_start(xs), .o_xfer_udma(xu), .o_xfer_ident(xi),
		.o_xfer_abort(xa), .i_xfer_done(xd), .i_drive_err(de), .i_phase_err(pe), .o_plain_valid(pv),
		.o_plain_block(pb));
	pab_tf_model tf (.i_clk_sys(clk), .i_rst(rst), .i_slow(slow), .i_tf_req(req), .i_tf_cmd(cmd), .o_tf_ack(ack),
		.o_tf_rdata(trd));
	// log taskfile writes, alt status reads, data phase and plain path
	always @(posedge clk) begin
		if (ack && cmd.we) wq.push_back({cmd.addr, cmd.wdata});
		if (ack && !cmd.we && cmd.addr == 3'h0) polls++;
		if (xs) xl <= {xi, xu};
		if (xa) aborts++;
		if (pv) pbk <= pb;
		xd <= xs && aut;
	end
	task automatic wrap_up;
		$display("checks %0d errors %0d", checks, err_count);
		if (err_count == 0 && checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic tmo(input int n);
		if (n >= 99) begin
			err_count++;
			wrap_up();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		awv <= 1'b1;
		wv <= 1'b1;
		awa <= a;
		wd <= d;
		bre <= 1'b1;
		for (n = 0; n < 99; n++) begin
			@(posedge clk);
			if (awr) awv <= 1'b0;
			if (wrd) wv <= 1'b0;
			if (bv) break;
		end
		r = br;
		bre <= 1'b0;
		tmo(n);
		@(posedge clk);
	endtask
	task automatic rdr(input logic [7:0] a);
		int n;
		arv <= 1'b1;
		ara <= a;
		rre <= 1'b1;
		for (n = 0; n < 99; n++) begin
			@(posedge clk);
			if (arr) arv <= 1'b0;
			if (rv) break;
		end
		st = rd;
		r = rr;
		rre <= 1'b0;
		tmo(n);
		@(posedge clk);
	endtask
	function automatic logic [127:0] mk(input logic [7:0] s, f, m, c);
		logic [127:0] b;
		for (int k = 0; k < 16; k++) b[8*k+:8] = 8'h60 + 8'(k);
		b[39:0] = {c, m, f, 8'h24, s};
		b[95:88] = 8'hE0;
		return b;
	endfunction
	task automatic run(input logic [127:0] b);
		int n;
		wq = {};
		for (n = 0; n < 4; n++) wr(pab_pkg::OFS_CB_W0 + 8'(4 * n), b[32*n+:32]);
		wr(pab_pkg::OFS_CTRL, 32'h1);
		for (n = 0; n < 99; n++) begin
			rdr(pab_pkg::OFS_STATUS);
			if (st[pab_pkg::STS_DONE]) break;
		end
		tmo(n);
	endtask
	task automatic s_plain;
		logic [127:0] b;
		rdr(8'h40);
		`CHK("unmapped", pab_pkg::RESP_SLVERR, r)
		wr(pab_pkg::OFS_CFG, 32'h1A5);
		`CHK("cfgresp", pab_pkg::RESP_OKAY, r)
		wr(pab_pkg::OFS_STATUS, 32'h0);
		`CHK("rowrite", pab_pkg::RESP_SLVERR, r)
		for (int i = 0; i < 2; i++) begin
			b = mk(i ? 8'hA5 : 8'h5A, 8'h00, 8'h00, 8'h01);
			if (i) b[15:8] = 8'h25;
			run(b);
			`CHK("routed", 1'b1, st[pab_pkg::STS_ROUTED])
			`CHK("plain", b, pbk)
		end
	endtask
	task automatic s_write;
		run(mk(8'hA5, 8'hE0, 8'h84, 8'h00));
		`CHK("ata", 1'b1, st[pab_pkg::STS_ATA])
		`CHK("polls", 3, polls)
		`CHK("early", {3'h6, 8'hE0, 3'h2, 8'h67, 3'h7, 8'h6C}, {wq[0], wq[1], wq[2]})
		`CHK("mode", 2'b11, xl)
		slow <= 1'b1;
		run(mk(8'hA5, 8'h06, 8'h84, 8'h80));
		`CHK("late", {3'h2, 8'h67, 3'h7, 8'h6C, 3'h6, 8'hF0}, {wq[0], wq[1], wq[2]})
		`CHK("mode", 2'b00, xl)
		`CHK("nopoll", 3, polls)
		run(mk(8'hA5, 8'h04, 8'h84, 8'h03));
		`CHK("fail", 1'b1, st[pab_pkg::STS_FAIL])
		`CHK("none", 0, wq.size())
	endtask
	task automatic s_read;
		run(mk(8'hA5, 8'h05, 8'h45, 8'h01));
		rdr(pab_pkg::OFS_RES_W0);
		`CHK("res0", 32'h00670050, st)
		rdr(pab_pkg::OFS_RES_W1);
		`CHK("res1", 32'h00F00000, st)
		run(mk(8'hA5, 8'h07, 8'h01, 8'h01));
		`CHK("rdlate", {3'h6, 8'hF0}, wq[0])
		rdr(pab_pkg::OFS_RES_W1);
		`CHK("res1z", 32'h00000000, st)
	endtask
	task automatic s_halt;
		aut <= 1'b0;
		de <= 1'b1;
		run(mk(8'hA5, 8'h04, 8'h80, 8'h01));
		`CHK("hdev", 1'b1, st[pab_pkg::STS_HALT_DEV])
		de <= 1'b0;
		pe <= 1'b1;
		run(mk(8'hA5, 8'h04, 8'h80, 8'h01));
		`CHK("hphase", 1'b1, st[pab_pkg::STS_HALT_PHASE])
		aut <= 1'b1;
		de <= 1'b1;
		run(mk(8'hA5, 8'h1C, 8'h80, 8'h01));
		`CHK("aborts", 2, aborts)
	endtask
	// reset, then the scenarios
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		s_plain();
		s_write();
		s_read();
		s_halt();
		wrap_up();
	end
endmodule
